/* File: ovng_pkg.sv */
// Package of constants, register map and state type for the output gain and noise gate block
package ovng_pkg;

  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NPATH    = 8;
  localparam int SAMPLE_W = 24;
  localparam int GIDX_W   = 10;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [11:0] IDX_RAMP = 12'h409;
  localparam logic [11:0] IDX_GCTL = 12'h458;
  localparam logic [11:0] IDX_TAP1 = 12'h450;
  localparam logic [11:0] IDX_TAP2 = 12'h451;
  // Path order 1L 1R 2L 2R 3L 3R 5L 5R, element 0 first
  localparam logic [7:0][11:0] IDX_VOL  = {12'h435, 12'h431, 12'h425, 12'h421,
                                           12'h41D, 12'h419, 12'h415, 12'h411};
  localparam logic [7:0][11:0] IDX_GSRC = {12'h437, 12'h433, 12'h427, 12'h423,
                                           12'h41F, 12'h41B, 12'h417, 12'h413};

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int VOL_MUTE_BIT = 8;
  localparam int VOL_UPD_BIT  = 9;
  localparam int GCTL_ENA_BIT = 0;
  localparam int GCTL_THR_LSB = 1;
  localparam int GCTL_HLD_LSB = 4;
  localparam int TAP_ENA_BIT  = 0;
  localparam int TAP_SRC_LSB  = 2;
  localparam int RAMP_VI_LSB  = 0;
  localparam int RAMP_VD_LSB  = 4;
  localparam logic [11:0] GSRC_WMASK = 12'h33F;
  // Mask bit that selects each path as a gate source
  localparam int SRC_BIT [8] = '{0, 1, 2, 3, 4, 5, 8, 9};

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0]       VOL_RST  = 8'h80;
  localparam logic             MUTE_RST = 1'b1;
  localparam logic [2:0]       RAMP_RST = 3'b010;
  localparam logic [2:0]       THR_RST  = 3'b000;
  localparam logic [1:0]       HOLD_RST = 2'b00;
  localparam logic [7:0][11:0] GSRC_RST = {12'h200, 12'h100, 12'h020, 12'h010,
                                           12'h008, 12'h004, 12'h002, 12'h001};

  // ------------------------------------------------------------------
  // Gain law: index in 0.125 dB units, zero is silence
  // ------------------------------------------------------------------
  localparam logic [9:0] GIDX_CODE_BASE = 10'h100;
  localparam int         GIDX_PER_OCT   = 48;
  localparam int         GAIN_SHIFT     = 22;
  // Gate thresholds, full-scale 24-bit magnitude, -78 dB down to -120 dB
  localparam logic [7:0][23:0] GATE_THR_LEVEL = {24'h00_0008, 24'h00_0011, 24'h00_0021, 24'h00_0043,
                                                 24'h00_0085, 24'h00_0109, 24'h00_0211, 24'h00_0420};

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_HZ  = 20_000_000;
  localparam int CLK_MHZ = CLK_HZ / 1_000_000;
  // Ramp time per 6 dB in microseconds; per-step cycles round down
  localparam int RAMP_TIME_US [8] = '{0, 500, 1000, 2000, 4000, 8000, 15000, 30000};
  localparam int RAMP_STEP_CYC [8] = '{
    RAMP_TIME_US[0] * CLK_MHZ / GIDX_PER_OCT, RAMP_TIME_US[1] * CLK_MHZ / GIDX_PER_OCT,
    RAMP_TIME_US[2] * CLK_MHZ / GIDX_PER_OCT, RAMP_TIME_US[3] * CLK_MHZ / GIDX_PER_OCT,
    RAMP_TIME_US[4] * CLK_MHZ / GIDX_PER_OCT, RAMP_TIME_US[5] * CLK_MHZ / GIDX_PER_OCT,
    RAMP_TIME_US[6] * CLK_MHZ / GIDX_PER_OCT, RAMP_TIME_US[7] * CLK_MHZ / GIDX_PER_OCT};
  // Gate hold base time, scaled by four per hold code
  localparam int HOLD_BASE_US = 1000;
  localparam int HOLD_BASE_CYC = HOLD_BASE_US * CLK_MHZ;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [0:0] {
    OVNG_APB_IDLE = 1'b0,
    OVNG_APB_ACK  = 1'b1
  } ovng_apb_st_t;

  typedef struct packed {
    logic [7:0][7:0]  pendCode;
    logic [7:0]       pendMute;
    logic [7:0][7:0]  applCode;
    logic [7:0]       applMute;
    logic [7:0][11:0] gsrc;
    logic [2:0]       rampVi;
    logic [2:0]       rampVd;
    logic             gEna;
    logic [2:0]       gThr;
    logic [1:0]       gHold;
    logic [1:0][3:0]  tapSrc;
    logic [1:0]       tapEna;
    logic [1:0]       tapSts;
    logic [7:0][9:0]  curIdx;
    logic [7:0]       gated;
    logic [7:0]       below;
    logic [7:0][23:0] holdCnt;
    logic [13:0]      tickVi;
    logic [13:0]      tickVd;
    logic [7:0][23:0] sampOut;
    logic             sampValid;
    logic [1:0][23:0] tapOut;
    logic [1:0]       tapValid;
    ovng_apb_st_t     apbSt;
    logic [15:0]      prdata;
  } ovng_state_t;

  localparam ovng_state_t STATE_RST = '{
    pendCode: {8{VOL_RST}}, pendMute: {8{MUTE_RST}},
    applCode: {8{VOL_RST}}, applMute: {8{MUTE_RST}},
    gsrc: GSRC_RST, rampVi: RAMP_RST, rampVd: RAMP_RST,
    gEna: 1'b0, gThr: THR_RST, gHold: HOLD_RST,
    tapSrc: 8'h00, tapEna: 2'b00, tapSts: 2'b00,
    curIdx: '0, gated: 8'h00, below: 8'h00, holdCnt: '0,
    tickVi: 14'h0000, tickVd: 14'h0000, sampOut: '0, sampValid: 1'b0,
    tapOut: '0, tapValid: 2'b00, apbSt: OVNG_APB_IDLE, prdata: 16'h0000};

endpackage

/* File: ovng_output_gain.sv */
// Output path volume, soft mute, noise gate and echo reference taps behind an APB slave
//
// Function
// [R1] Volume code: 0 -64 dB, 0.5 dB steps
// [R2] Codes 0xC0-0xFF reserved; volume resets unity
// [R3] Bit 8 mutes path; reset muted
// [R4] Update bit 9 applies all paths together
// [R5] Update bit write-only, reads zero
// [R6] Gate mutes paths whose sources stay quiet
// [R7] Global gate enable bit 0, reset off
// [R8] Twelve-bit mask; all selected sources must be quiet
// [R9] Mask bits 0-5, 8, 9 select paths
// [R10] Each mask resets to its own path
// [R11] Shared threshold bits 3:1, -78 to -120 dB
// [R12] Threshold measured after volume, unaffected by gating
// [R13] Each path gates and releases independently
// [R14] Gate only after hold time, bits 5:4
// [R15] Gate ramps down and up at rates
// [R16] Two taps offer volume-stage output to mixers; the code taps the gated output instead
// [R17] Tap source code selects tapped path
// [R18] Taps run at the output sample rate
// [R19] Tap enable refused when clock too slow
// [R20] Read-only flag shows tap really enabled
// [R21] Written volume pending until update strobe
// [R22] Tap enable bit 0, status bit 1
// [R23] Ramp codes 0 to 30 ms per 6 dB
// [R24] Loud source restarts hold, releases gate
// [R25] Gain ramps in 0.125 dB internal steps
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module ovng_output_gain #(
  parameter logic [13:0] RAMP_15MS_STEP_CYC = 14'(ovng_pkg::RAMP_STEP_CYC[6]),
  parameter logic [13:0] RAMP_30MS_STEP_CYC = 14'(ovng_pkg::RAMP_STEP_CYC[7]),
  parameter logic [23:0] HOLD_BASE_CYC      = 24'(ovng_pkg::HOLD_BASE_CYC)
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [15:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Audio from the mixing core
  input  wire logic [7:0][23:0] pathSampleIn,
  input  wire logic             sampleStrobe,
  input  wire logic             systemCoreClockOk,
  // Audio to the output drivers
  output logic      [7:0][23:0] pathSampleOut,
  output logic                  pathSampleValid,
  output logic      [7:0]       pathGated,
  // Echo reference taps to the mixers
  output logic      [1:0][23:0] echoTapSample,
  output logic      [1:0]       echoTapValid,
  output logic      [1:0]       echoTapActiveFlag
);

  // ------------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------------

  // Gain index to linear gain; octaves by shift, mantissa piecewise linear
  function automatic logic [23:0] applyGain(input logic [23:0] s, input logic [9:0] idx);
    logic [4:0]         oct;
    logic [5:0]         rem;
    logic [7:0]         mant;
    logic signed [55:0] prod;
    logic signed [55:0] sh;
    logic [23:0]        r;
    oct  = 5'(idx / 10'd48);
    rem  = 6'(idx % 10'd48);
    mant = 8'd64 + 8'((10'(rem) * 10'd21) >> 4);               // see [R25]
    prod = 56'($signed(s)) * $signed({48'h0000_0000_0000, mant});
    sh   = (prod <<< oct) >>> ovng_pkg::GAIN_SHIFT;
    // Saturate rather than wrap at high gain
    if (idx == 10'h000) begin
      r = 24'h00_0000;
    end else if (sh > 56'sh0_0000_0000_7F_FFFF) begin
      r = 24'h7F_FFFF;
    end else if (sh < -56'sh0_0000_0000_80_0000) begin
      r = 24'h80_0000;
    end else begin
      r = sh[23:0];
    end
    return r;
  endfunction

  // Volume code to gain index, 4 internal steps per code
  function automatic logic [9:0] codeToIdx(input logic [7:0] code);
    return ovng_pkg::GIDX_CODE_BASE + {code, 2'b00};           // see [R1]
  endfunction

  // Source mask to path vector, reserved bits ignored
  function automatic logic [7:0] maskToPaths(input logic [11:0] m);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < ovng_pkg::NPATH; i++) begin
      r[i] = m[ovng_pkg::SRC_BIT[i]];                          // see [R9]
    end
    return r;
  endfunction

  // Register index lookup in a per-path table: {hit, path}
  function automatic logic [3:0] matchIdx(input logic [11:0] idx, input logic [7:0][11:0] tbl);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < ovng_pkg::NPATH; i++) begin
      if (idx == tbl[i]) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  // Tap source code to path: {valid, path}
  function automatic logic [3:0] tapCodeToPath(input logic [3:0] code);
    logic [3:0] r;
    if (code <= 4'h5) begin                                    // see [R17]
      r = {1'b1, code[2:0]};
    end else if (code == 4'h8) begin
      r = 4'hE;
    end else if (code == 4'h9) begin
      r = 4'hF;
    end else begin
      r = 4'h0;
    end
    return r;
  endfunction

  // Ramp step length in cycles; zero means jump at once
  function automatic logic [13:0] rampStep(input logic [2:0] code);
    logic [13:0] r;
    case (code)                                                // see [R23]
      3'd6:    r = RAMP_15MS_STEP_CYC;
      3'd7:    r = RAMP_30MS_STEP_CYC;
      default: r = 14'(ovng_pkg::RAMP_STEP_CYC[code]);
    endcase
    return r;
  endfunction

  // 16-bit register merge under APB byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sb);
    logic [15:0] r;
    r[7:0]  = sb[0] ? wd[7:0]  : old[7:0];
    r[15:8] = sb[1] ? wd[15:8] : old[15:8];
    return r;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  ovng_pkg::ovng_state_t st_ff;
  ovng_pkg::ovng_state_t nxt_st;

  logic [7:0][23:0] ungatedOut;
  logic [7:0][23:0] gatedOut;
  logic [7:0]       belowNow;
  logic [7:0]       selQuiet;
  logic [7:0][9:0]  tgtIdx;
  logic [11:0]      aIdx;
  logic [3:0]       volHit;
  logic [3:0]       srcHit;
  logic [15:0]      rdVal;
  logic             mapped;
  logic [15:0]      wrVal;
  logic             wrNow;
  logic [13:0]      stepVi;
  logic [13:0]      stepVd;
  logic             tickVi;
  logic             tickVd;
  logic [23:0]      holdLimit;
  logic [1:0][3:0]  tapPath;

  // ------------------------------------------------------------------
  // Per-path datapath
  // ------------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < ovng_pkg::NPATH; gp++) begin : g_path
      logic [7:0]  srcPaths;
      logic [23:0] mag;
      // Detector sees volume-stage level, never the gate's own attenuation
      assign ungatedOut[gp] = applyGain(pathSampleIn[gp], codeToIdx(st_ff.applCode[gp])); // see [R12]
      assign gatedOut[gp]   = applyGain(pathSampleIn[gp], st_ff.curIdx[gp]);
      assign mag            = ungatedOut[gp][23] ? 24'(-ungatedOut[gp]) : ungatedOut[gp];
      assign belowNow[gp]   = mag < ovng_pkg::GATE_THR_LEVEL[st_ff.gThr];               // see [R11]
      // Quiet only when every selected source is quiet; empty mask never gates
      assign srcPaths       = maskToPaths(st_ff.gsrc[gp]);
      assign selQuiet[gp]   = (srcPaths != 8'h00) && ((st_ff.below & srcPaths) == srcPaths); // see [R8]
      // Mute and gate both pull the target to silence
      assign tgtIdx[gp]     = (st_ff.applMute[gp] || st_ff.gated[gp]) ? 10'h000
                                                                       : codeToIdx(st_ff.applCode[gp]); // see [R3]
    end
  endgenerate

  // ------------------------------------------------------------------
  // Shared ramp ticks and hold limit
  // ------------------------------------------------------------------
  assign stepVi    = rampStep(st_ff.rampVi);
  assign stepVd    = rampStep(st_ff.rampVd);
  assign tickVi    = (st_ff.tickVi >= stepVi - 14'd1);
  assign tickVd    = (st_ff.tickVd >= stepVd - 14'd1);
  // Four times longer per hold code
  assign holdLimit = HOLD_BASE_CYC << {st_ff.gHold, 1'b0};      // see [R14]

  // ------------------------------------------------------------------
  // Register decode and read mux
  // ------------------------------------------------------------------
  assign aIdx   = paddr[13:2];
  assign volHit = matchIdx(aIdx, ovng_pkg::IDX_VOL);
  assign srcHit = matchIdx(aIdx, ovng_pkg::IDX_GSRC);

  // Read value of the addressed register; update bit always reads zero
  always_comb begin
    rdVal  = 16'h0000;
    mapped = 1'b1;
    if (volHit[3]) begin
      rdVal = {6'h00, 1'b0, st_ff.pendMute[volHit[2:0]], st_ff.pendCode[volHit[2:0]]}; // see [R5]
    end else if (srcHit[3]) begin
      rdVal = {4'h0, st_ff.gsrc[srcHit[2:0]]};
    end else if (aIdx == ovng_pkg::IDX_GCTL) begin
      rdVal = {10'h000, st_ff.gHold, st_ff.gThr, st_ff.gEna};
    end else if (aIdx == ovng_pkg::IDX_TAP1) begin
      rdVal = {10'h000, st_ff.tapSrc[0], st_ff.tapSts[0], st_ff.tapEna[0]}; // see [R20]
    end else if (aIdx == ovng_pkg::IDX_TAP2) begin
      rdVal = {10'h000, st_ff.tapSrc[1], st_ff.tapSts[1], st_ff.tapEna[1]};
    end else if (aIdx == ovng_pkg::IDX_RAMP) begin
      rdVal = {9'h000, st_ff.rampVd, 1'b0, st_ff.rampVi};
    end else begin
      mapped = 1'b0;
    end
  end

  assign wrVal = merge16(rdVal, pwdata, pstrb);
  // Writes land only on the completing edge of the access
  assign wrNow = psel && penable && pwrite && mapped && (st_ff.apbSt == ovng_pkg::OVNG_APB_ACK);

  assign tapPath[0] = tapCodeToPath(st_ff.tapSrc[0]);
  assign tapPath[1] = tapCodeToPath(st_ff.tapSrc[1]);

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Free-running ramp prescalers
    nxt_st.tickVi = tickVi ? 14'h0000 : st_ff.tickVi + 14'd1;
    nxt_st.tickVd = tickVd ? 14'h0000 : st_ff.tickVd + 14'd1;

    for (int p = 0; p < ovng_pkg::NPATH; p++) begin
      // Gain ramps one 0.125 dB step per tick toward target
      if (st_ff.curIdx[p] < tgtIdx[p]) begin
        if (st_ff.rampVi == 3'b000) begin
          nxt_st.curIdx[p] = tgtIdx[p];
        end else if (tickVi) begin
          nxt_st.curIdx[p] = st_ff.curIdx[p] + 10'd1;          // see [R15]
        end
      end else if (st_ff.curIdx[p] > tgtIdx[p]) begin
        if (st_ff.rampVd == 3'b000) begin
          nxt_st.curIdx[p] = tgtIdx[p];
        end else if (tickVd) begin
          nxt_st.curIdx[p] = st_ff.curIdx[p] - 10'd1;          // see [R15]
        end
      end

      // Gate hold timing, independent per path
      if (!st_ff.gEna) begin
        nxt_st.gated[p]   = 1'b0;                              // see [R7]
        nxt_st.holdCnt[p] = 24'h00_0000;
      end else if (!selQuiet[p]) begin
        nxt_st.gated[p]   = 1'b0;                              // see [R24]
        nxt_st.holdCnt[p] = 24'h00_0000;
      end else if (st_ff.holdCnt[p] > holdLimit) begin
        nxt_st.gated[p]   = 1'b1;                              // see [R6] [R13]
      end else begin
        nxt_st.holdCnt[p] = st_ff.holdCnt[p] + 24'd1;          // see [R14]
      end

      // Sample path and level detector advance at the output rate
      if (sampleStrobe) begin
        nxt_st.sampOut[p] = gatedOut[p];
        nxt_st.below[p]   = belowNow[p];
      end
    end
    nxt_st.sampValid = sampleStrobe;

    // Echo taps pick a path's gated output, after gate and mute; reserved code gives silence
    for (int t = 0; t < 2; t++) begin
      nxt_st.tapValid[t] = sampleStrobe && st_ff.tapSts[t];    // see [R18]
      if (sampleStrobe) begin
        nxt_st.tapOut[t] = (st_ff.tapSts[t] && tapPath[t][3]) ? gatedOut[tapPath[t][2:0]]
                                                               : 24'h00_0000; // see [R16]
      end
    end

    // APB: one wait state so read data comes from a flop
    case (st_ff.apbSt)
      ovng_pkg::OVNG_APB_IDLE: begin
        if (psel && penable) begin
          nxt_st.apbSt  = ovng_pkg::OVNG_APB_ACK;
          nxt_st.prdata = rdVal;
        end
      end
      default: begin
        nxt_st.apbSt = ovng_pkg::OVNG_APB_IDLE;
      end
    endcase

    // Register writes
    if (wrNow) begin
      if (volHit[3]) begin
        // Stored as pending; gain untouched until the strobe
        nxt_st.pendCode[volHit[2:0]] = wrVal[7:0];             // see [R21]
        nxt_st.pendMute[volHit[2:0]] = wrVal[ovng_pkg::VOL_MUTE_BIT]; // see [R3]
      end else if (srcHit[3]) begin
        nxt_st.gsrc[srcHit[2:0]] = wrVal[11:0] & ovng_pkg::GSRC_WMASK; // see [R9]
      end else if (aIdx == ovng_pkg::IDX_GCTL) begin
        nxt_st.gEna  = wrVal[ovng_pkg::GCTL_ENA_BIT];          // see [R7]
        nxt_st.gThr  = wrVal[ovng_pkg::GCTL_THR_LSB +: 3];     // see [R11]
        nxt_st.gHold = wrVal[ovng_pkg::GCTL_HLD_LSB +: 2];     // see [R14]
      end else if (aIdx == ovng_pkg::IDX_RAMP) begin
        nxt_st.rampVi = wrVal[ovng_pkg::RAMP_VI_LSB +: 3];     // see [R23]
        nxt_st.rampVd = wrVal[ovng_pkg::RAMP_VD_LSB +: 3];
      end else begin
        // Tap control; status follows enable only with enough clock
        for (int t = 0; t < 2; t++) begin
          if (aIdx == (t == 0 ? ovng_pkg::IDX_TAP1 : ovng_pkg::IDX_TAP2)) begin
            nxt_st.tapSrc[t] = wrVal[ovng_pkg::TAP_SRC_LSB +: 4]; // see [R17]
            nxt_st.tapEna[t] = wrVal[ovng_pkg::TAP_ENA_BIT];      // see [R22]
            nxt_st.tapSts[t] = wrVal[ovng_pkg::TAP_ENA_BIT] && systemCoreClockOk; // see [R19] [R20]
          end
        end
      end
    end

    // Update strobe copies all pending settings at once, this write included
    if (wrNow && volHit[3] && pstrb[1] && pwdata[ovng_pkg::VOL_UPD_BIT]) begin
      nxt_st.applCode = nxt_st.pendCode;                       // see [R4]
      nxt_st.applMute = nxt_st.pendMute;
    end
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Reset loads the defaults: unity code, muted, own-path masks
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ovng_pkg::STATE_RST;                            // see [R2] [R10]
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata            = {16'h0000, st_ff.prdata};
  assign pready            = psel && penable && (st_ff.apbSt == ovng_pkg::OVNG_APB_ACK);
  assign pslverr           = pready && !mapped;
  assign pathSampleOut     = st_ff.sampOut;
  assign pathSampleValid   = st_ff.sampValid;
  assign pathGated         = st_ff.gated;
  assign echoTapSample     = st_ff.tapOut;
  assign echoTapValid      = st_ff.tapValid;
  assign echoTapActiveFlag = st_ff.tapSts;

endmodule // ovng_output_gain

`default_nettype wire

/* File: ovng_chk.sv */
// Port-level assertions of the gain and gate block
`timescale 1ns/100ps
`default_nettype none
module ovng_chk (
  // Bus
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Audio side
  input wire logic        sampleStrobe,
  input wire logic        systemCoreClockOk,
  input wire logic        pathSampleValid,
  input wire logic [7:0]  pathGated,
  input wire logic [1:0]  echoTapValid,
  input wire logic [1:0]  echoTapActiveFlag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------
  // Properties
  // ----------------
  property p_val; sampleStrobe |=> pathSampleValid; endproperty
  property p_noval; !sampleStrobe |=> !pathSampleValid; endproperty
  property p_tapv; echoTapValid[0] |-> $past(sampleStrobe); endproperty
  property p_rdy; pready |-> psel && penable && $past(psel && penable); endproperty
  property p_one; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  // Status rises only on a write with enough clock
  property p_flag; $rose(echoTapActiveFlag[0]) |-> $past(systemCoreClockOk && pready && pwrite); endproperty
  property p_keep; !$stable(echoTapActiveFlag) |-> $past(pready && pwrite); endproperty
  // Gate state was computed from the old enable at the write edge
  property p_gdis;
    pready && pwrite && paddr[13:2] == ovng_pkg::IDX_GCTL && !pwdata[0] |-> ##2 pathGated == 8'h00;
  endproperty
  a_val: assert property (p_val) else $error("no valid");
  a_noval: assert property (p_noval) else $error("stray valid");
  a_tapv: assert property (p_tapv) else $error("tap valid");
  a_rdy: assert property (p_rdy) else $error("bad ready");
  a_one: assert property (p_one) else $error("ready held");
  a_err: assert property (p_err) else $error("bad error");
  a_flag: assert property (p_flag) else $error("underclocked tap");
  a_keep: assert property (p_keep) else $error("status moved");
  a_gdis: assert property (p_gdis) else $error("gate kept");
  // Scenarios
  c_gate: cover property ($rose(pathGated[0]));
  c_tap: cover property ($rose(echoTapActiveFlag[0]));
  c_err: cover property (pslverr);
endmodule // ovng_chk
bind ovng_output_gain ovng_chk u_chk (.*);
`default_nettype wire

/* File: ovng_tb_top.sv */
// Self-checking testbench of the gain and gate block
`timescale 1ns/100ps
`default_nettype none
module ovng_tb_top;
  // ----------------
  // Signals
  // ----------------
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
  logic sampleStrobe = 1'b0, systemCoreClockOk = 1'b0, pready, pslverr, pathSampleValid;
  logic [15:0] paddr = 16'h0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [7:0][23:0] pathSampleIn = '0, pathSampleOut;
  logic [1:0][23:0] echoTapSample;
  logic [7:0] pathGated, code [8];
  logic [1:0] echoTapValid, echoTapActiveFlag;
  int miscompares = 0, n_checks = 0, ph = 0;
  // Clock, strobe every fourth cycle
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    ph <= (ph + 1) % 4;
    sampleStrobe <= (ph == 3);
  end
  // Short ramp and hold counts keep the run brief
  ovng_output_gain #(.RAMP_15MS_STEP_CYC(14'h0014), .RAMP_30MS_STEP_CYC(14'h0028), .HOLD_BASE_CYC(24'h00_0010)) dut (.*);
  // APB transfer, held until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] ix, input logic [15:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, ix, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Expected output per gain code
  function automatic logic [23:0] expOut(input int p);
    if (code[p] == 8'h8C) return pathSampleIn[p] << 1;
    if (code[p] == 8'h74) return $signed(pathSampleIn[p]) >>> 1;
    return pathSampleIn[p];
  endfunction
  // Watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(32'ha16a_0b8b));
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int p = 0; p < 8; p++) begin
      code[p] = 8'h80;
      pathSampleIn[p] <= 24'h00_1000 + 24'($urandom_range(32'h0000_7FFF));
      apb(1'b0, ovng_pkg::IDX_VOL[p], 16'h0000);
      chk(rd, 32'h0000_0180, "volume reset");
      apb(1'b0, ovng_pkg::IDX_GSRC[p], 16'h0000);
      chk(rd, 32'(p < 6 ? 1 << p : 1 << (p + 2)), "mask reset");
    end
    apb(1'b0, ovng_pkg::IDX_RAMP, 16'h0000);
    chk(rd, 32'h0000_0022, "ramp reset");
    apb(1'b0, ovng_pkg::IDX_GCTL, 16'h0000);
    chk(rd, 32'h0000_0000, "gate reset");
    apb(1'b0, 12'h400, 16'h0000);
    chk(32'(er), 32'h0000_0001, "unmapped");
    apb(1'b1, ovng_pkg::IDX_GSRC[0], 16'hFFFF);
    apb(1'b0, ovng_pkg::IDX_GSRC[0], 16'h0000);
    chk(rd, 32'h0000_033F, "mask bits");
    apb(1'b1, ovng_pkg::IDX_GSRC[0], 16'h0001);
    $display("test registers done");
    apb(1'b1, ovng_pkg::IDX_RAMP, 16'h0000);
    for (int p = 0; p < 8; p++) apb(1'b1, ovng_pkg::IDX_VOL[p], 16'h0080);
    wt(12);
    for (int p = 0; p < 8; p++) chk(32'(pathSampleOut[p]), 32'h0000_0000, "pending");
    code[0] = 8'h8C;
    code[1] = 8'h74;
    apb(1'b1, ovng_pkg::IDX_VOL[0], 16'h008C);
    apb(1'b1, ovng_pkg::IDX_VOL[1], 16'h0074);
    apb(1'b1, ovng_pkg::IDX_VOL[7], 16'h0280);
    wt(12);
    for (int p = 0; p < 8; p++) chk(32'(pathSampleOut[p]), 32'(expOut(p)), "gain");
    apb(1'b0, ovng_pkg::IDX_VOL[7], 16'h0000);
    chk(rd, 32'h0000_0080, "update bit");
    $display("test volume done");
    apb(1'b1, ovng_pkg::IDX_TAP1, 16'h0001);
    wt(2);
    chk(32'(echoTapActiveFlag), 32'h0000_0000, "refused tap");
    @(posedge ref_clk);
    systemCoreClockOk <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      apb(1'b1, ovng_pkg::IDX_TAP1, {10'h000, 4'(k < 6 ? k : k + 2), 2'b01});
      wt(8);
      chk(32'(echoTapSample[0]), 32'(expOut(k)), "tap sample");
    end
    apb(1'b1, ovng_pkg::IDX_TAP2, 16'h0029);
    systemCoreClockOk <= 1'b0;
    wt(8);
    chk(32'(echoTapSample[1]), 32'h0000_0000, "reserved tap");
    chk(32'(echoTapActiveFlag), 32'h0000_0003, "tap status");
    $display("test taps done");
    apb(1'b1, ovng_pkg::IDX_GSRC[1], 16'h0003);
    apb(1'b1, ovng_pkg::IDX_GCTL, 16'h000F);
    pathSampleIn[0] <= 24'h00_0064;
    wt(40);
    chk(32'(pathGated), 32'h0000_0000, "lowest threshold");
    apb(1'b1, ovng_pkg::IDX_GCTL, 16'h0001);
    wt(8);
    chk(32'(pathGated), 32'h0000_0000, "hold time");
    wt(40);
    chk(32'(pathGated), 32'h0000_0001, "quiet path");
    chk(32'(pathSampleOut[0]), 32'h0000_0000, "gated output");
    pathSampleIn[1] <= 24'h00_0064;
    wt(40);
    chk(32'(pathGated), 32'h0000_0003, "both quiet");
    @(posedge ref_clk);
    pathSampleIn[0] <= 24'h00_4000;
    wt(12);
    chk(32'(pathGated), 32'h0000_0000, "release");
    apb(1'b1, ovng_pkg::IDX_GCTL, 16'h0000);
    wt(2);
    $display("test gate done");
    give_verdict();
  end
endmodule // ovng_tb_top
`default_nettype wire
